// File: hdl/epc_config.v
// Notes on behaviour
// - identifier bit 31 set disables message
// - bit 29 picks 11-bit or 29-bit identifier
// - identifier resets to C0000480h plus address
// - switch address forces identifier default at power-on
// - only types 01h-F0h and FEh; FEh default
// - type 0 stored but never sends
// - other unsupported types abort 06090030h
// - FEh sends every timer interval, zero never
// - synchronous type n sends every n SYNCs
// - identifier MSB clear enables each of four messages
// - mapping word index, subindex, length fields
// - mapping words reset to position/velocity objects
// - low limit flag in status bit 12
// - high limit flag in status bit 13
// - rate code 00h-07h, default 05h
// - rate switch 4 on selects switch bank
// - address 1..127, default 1, software when switches off
// - any address switch on overrides software address
// - boot-up on 700h plus address, byte 00
// - unsaved parameters lost at power-off
`include "epc_defines.vh"
`default_nettype none
module epc_config (
   // clock and reset
   input  wire        CORE_CLK,
   input  wire        RESET,
   // power-on strobe: set by power-up logic, otherwise a warm node reset
   input  wire        POWER_ON,
   input  wire        FORCE_ADDR_SET,
   // configuration access from the protocol engine
   input  wire        CFG_WRITE,
   input  wire        CFG_READ,
   input  wire [3:0]  CFG_OBJECT,
   input  wire [31:0] CFG_WDATA,
   output reg  [31:0] CFG_RDATA,
   output reg         CFG_DONE,
   output reg         CFG_ABORT,
   output reg  [31:0] CFG_ABORT_CODE,
   // bus events
   input  wire        SYNC_SEEN,
   input  wire        NODE_RESET,
   // position from the sensor
   input  wire [31:0] POSITION,
   // switch banks (asynchronous pins)
   input  wire [3:0]  BIT_RATE_SWITCH_BANK,
   input  wire [6:0]  NODE_ADDRESS_SWITCH_BANK,
   // derived outputs
   output reg  [2:0]  ACTIVE_RATE,
   output reg  [6:0]  ACTIVE_ADDRESS,
   output reg  [15:0] STATUS_WORD,
   // message requests
   output reg         VEL_SEND,
   output reg  [28:0] VEL_IDENT,
   output reg         VEL_IDENT_EXT,
   output reg  [3:0]  MSG_ENABLE,
   output reg         BOOT_SEND,
   output reg  [10:0] BOOT_IDENT,
   output reg         STORE_REQ
);

   // boot sequence states
   localparam ST_IDLE = 3'b001;
   localparam ST_APPLY = 3'b010;
   localparam ST_BOOT = 3'b100;

   reg [3:0]  rate_sw_m;
   reg [3:0]  rate_sw;
   reg [6:0]  addr_sw_m;
   reg [6:0]  addr_sw;
   reg [31:0] velocity_msg_identifier;
   reg [7:0]  velocity_msg_transmit_type;
   reg [31:0] first_msg_mapping;
   reg [31:0] second_msg_mapping;
   reg [31:0] third_msg_mapping;
   reg [31:0] fourth_msg_mapping;
   reg [31:0] low_position_limit;
   reg [31:0] high_position_limit;
   reg [7:0]  bit_rate_code;
   reg [7:0]  node_address;
   reg [15:0] control_word;
   reg [15:0] cyclic_timer;
   reg [31:0] other_ident [0:2];
   reg [2:0]  state;
   reg [7:0]  sync_count;
   reg [15:0] ms_count;
   reg [14:0] tick_count;
   reg        dirty;
   reg        store_seen;
   wire       tick;
   wire       addr_from_sw;
   wire       tx_ok;
   wire       tx_zero;
   wire [6:0] next_address;
   reg        cold_start;
   integer    i;

   // two flops on the switch pins before any use
   always @(posedge CORE_CLK) begin
      rate_sw_m <= BIT_RATE_SWITCH_BANK;
      rate_sw <= rate_sw_m;
      addr_sw_m <= NODE_ADDRESS_SWITCH_BANK;
      addr_sw <= addr_sw_m;
   end

   assign addr_from_sw = |addr_sw;
   // address that the next apply step takes
   assign next_address = addr_from_sw ? addr_sw : node_address[6:0];
   // accepted transmission types
   assign tx_zero = (CFG_WDATA[7:0] == 8'h00);
   assign tx_ok = (CFG_WDATA[7:0] != 8'h00 && CFG_WDATA[7:0] <= `EPC_TX_SYNC_MAX)
                  || CFG_WDATA[7:0] == `EPC_TX_ASYNC;

   // millisecond tick for the cyclic timer
   assign tick = (tick_count == `EPC_TICK_LAST);
   always @(posedge CORE_CLK) begin
      if (RESET || tick) begin
         tick_count <= 15'h0000;
      end else begin
         tick_count <= tick_count + 15'h0001;
      end
   end

   // configuration store and access handshake
   always @(posedge CORE_CLK) begin
      CFG_DONE <= 1'b0;
      CFG_ABORT <= 1'b0;
      STORE_REQ <= 1'b0;
      if (RESET) begin
         velocity_msg_identifier <= `EPC_IDENT_BASE + 32'h00000001;
         velocity_msg_transmit_type <= `EPC_TXTYPE_RST;
         first_msg_mapping <= `EPC_MAP_POS_RST;
         second_msg_mapping <= `EPC_MAP_POS_RST;
         third_msg_mapping <= `EPC_MAP_POS_RST;
         fourth_msg_mapping <= `EPC_MAP_VEL_RST;
         low_position_limit <= `EPC_LOWLIM_RST;
         high_position_limit <= `EPC_HIGHLIM_RST;
         bit_rate_code <= `EPC_RATE_RST;
         node_address <= `EPC_ADDR_RST;
         control_word <= 16'h0000;
         cyclic_timer <= 16'h0000;
         for (i = 0; i < 3; i = i + 1) begin
            other_ident[i] <= 32'hC0000000;
         end
         CFG_ABORT_CODE <= 32'h00000000;
         CFG_RDATA <= 32'h00000000;
         dirty <= 1'b0;
         store_seen <= 1'b0;
         cold_start <= POWER_ON; // only a cold start may force the default
      end else begin
         // forced default when the switch bank sets the address; takes the
         // address being applied, as the active one only changes at this edge
         if (state == ST_APPLY && cold_start && (addr_from_sw || FORCE_ADDR_SET)) begin
            velocity_msg_identifier <= `EPC_IDENT_BASE + {25'h0000000, next_address};
         end
         if (state == ST_APPLY) begin
            cold_start <= 1'b0;
         end
         if (CFG_WRITE) begin
            CFG_DONE <= 1'b1;
            if (CFG_OBJECT == `EPC_OBJ_IDENT) begin
               velocity_msg_identifier <= CFG_WDATA;
               dirty <= 1'b1;
            end else if (CFG_OBJECT == `EPC_OBJ_TXTYPE) begin
               if (tx_ok || tx_zero) begin
                  velocity_msg_transmit_type <= CFG_WDATA[7:0];
                  dirty <= 1'b1;
               end else begin
                  CFG_DONE <= 1'b0;
                  CFG_ABORT <= 1'b1;
                  CFG_ABORT_CODE <= `EPC_ABORT_BADVAL;
               end
            end else if (CFG_OBJECT == `EPC_OBJ_MAP1) begin
               first_msg_mapping <= CFG_WDATA;
            end else if (CFG_OBJECT == `EPC_OBJ_MAP2) begin
               second_msg_mapping <= CFG_WDATA;
            end else if (CFG_OBJECT == `EPC_OBJ_MAP3) begin
               third_msg_mapping <= CFG_WDATA;
            end else if (CFG_OBJECT == `EPC_OBJ_MAP4) begin
               fourth_msg_mapping <= CFG_WDATA;
            end else if (CFG_OBJECT == `EPC_OBJ_LOWLIM) begin
               low_position_limit <= CFG_WDATA;
            end else if (CFG_OBJECT == `EPC_OBJ_HIGHLIM) begin
               high_position_limit <= CFG_WDATA;
            end else if (CFG_OBJECT == `EPC_OBJ_RATE) begin
               if (CFG_WDATA[7:0] <= 8'h07) begin
                  bit_rate_code <= CFG_WDATA[7:0];
               end else begin
                  CFG_DONE <= 1'b0;
                  CFG_ABORT <= 1'b1;
                  CFG_ABORT_CODE <= `EPC_ABORT_BADVAL;
               end
            end else if (CFG_OBJECT == `EPC_OBJ_ADDR) begin
               if (CFG_WDATA[7:0] != 8'h00 && CFG_WDATA[7:0] <= `EPC_ADDR_MAX) begin
                  node_address <= CFG_WDATA[7:0];
               end else begin
                  CFG_DONE <= 1'b0;
                  CFG_ABORT <= 1'b1;
                  CFG_ABORT_CODE <= `EPC_ABORT_BADVAL;
               end
            end else if (CFG_OBJECT == `EPC_OBJ_CTRL) begin
               control_word <= CFG_WDATA[15:0];
            end else if (CFG_OBJECT == `EPC_OBJ_TIMER) begin
               cyclic_timer <= CFG_WDATA[15:0];
            end else if (CFG_OBJECT == `EPC_OBJ_STORE) begin
               // saving is done by the non-volatile store outside
               STORE_REQ <= 1'b1;
               store_seen <= 1'b1;
               dirty <= 1'b0;
            end
            if (CFG_OBJECT != `EPC_OBJ_STORE && CFG_OBJECT != `EPC_OBJ_TXTYPE
                && CFG_OBJECT != `EPC_OBJ_IDENT) begin
               dirty <= 1'b1;
            end
         end else if (CFG_READ) begin
            CFG_DONE <= 1'b1;
            if (CFG_OBJECT == `EPC_OBJ_IDENT) begin
               CFG_RDATA <= velocity_msg_identifier;
            end else if (CFG_OBJECT == `EPC_OBJ_TXTYPE) begin
               CFG_RDATA <= {24'h000000, velocity_msg_transmit_type};
            end else if (CFG_OBJECT == `EPC_OBJ_MAP1) begin
               CFG_RDATA <= first_msg_mapping;
            end else if (CFG_OBJECT == `EPC_OBJ_MAP2) begin
               CFG_RDATA <= second_msg_mapping;
            end else if (CFG_OBJECT == `EPC_OBJ_MAP3) begin
               CFG_RDATA <= third_msg_mapping;
            end else if (CFG_OBJECT == `EPC_OBJ_MAP4) begin
               CFG_RDATA <= fourth_msg_mapping;
            end else if (CFG_OBJECT == `EPC_OBJ_LOWLIM) begin
               CFG_RDATA <= low_position_limit;
            end else if (CFG_OBJECT == `EPC_OBJ_HIGHLIM) begin
               CFG_RDATA <= high_position_limit;
            end else if (CFG_OBJECT == `EPC_OBJ_RATE) begin
               CFG_RDATA <= {24'h000000, bit_rate_code};
            end else if (CFG_OBJECT == `EPC_OBJ_ADDR) begin
               CFG_RDATA <= {24'h000000, node_address};
            end else if (CFG_OBJECT == `EPC_OBJ_CTRL) begin
               CFG_RDATA <= {16'h0000, control_word};
            end else if (CFG_OBJECT == `EPC_OBJ_TIMER) begin
               CFG_RDATA <= {16'h0000, cyclic_timer};
            end else if (CFG_OBJECT == `EPC_OBJ_STORE) begin
               CFG_RDATA <= {30'h00000000, store_seen, dirty};
            end else begin
               CFG_RDATA <= 32'h00000000;
            end
         end
      end
   end

   // reset/boot sequence: apply rate and address, then boot-up message
   always @(posedge CORE_CLK) begin
      BOOT_SEND <= 1'b0;
      if (RESET) begin
         state <= ST_APPLY;
         ACTIVE_RATE <= 3'h5;
         ACTIVE_ADDRESS <= 7'h01;
         BOOT_IDENT <= `EPC_BOOT_BASE;
      end else begin
         case (state)
            ST_IDLE: begin
               if (NODE_RESET) begin
                  state <= ST_APPLY;
               end
            end
            ST_APPLY: begin
               // new settings only take effect at a reset
               if (rate_sw[3]) begin
                  ACTIVE_RATE <= rate_sw[2:0];
               end else begin
                  ACTIVE_RATE <= bit_rate_code[2:0];
               end
               if (addr_from_sw) begin
                  ACTIVE_ADDRESS <= addr_sw;
               end else begin
                  ACTIVE_ADDRESS <= node_address[6:0];
               end
               state <= ST_BOOT;
            end
            ST_BOOT: begin
               BOOT_SEND <= 1'b1;
               BOOT_IDENT <= `EPC_BOOT_BASE + {4'h0, ACTIVE_ADDRESS};
               state <= ST_IDLE;
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // limit comparators; flags clear while their check is disabled
   always @(posedge CORE_CLK) begin
      if (RESET) begin
         STATUS_WORD <= 16'h0000;
      end else begin
         STATUS_WORD <= {2'b00, control_word[13:12], 12'h000};
         if (control_word[`EPC_CTRL_LOW_EN]) begin
            STATUS_WORD[`EPC_CTRL_LOW_EN] <= (POSITION < low_position_limit);
         end
         if (control_word[`EPC_CTRL_HIGH_EN]) begin
            STATUS_WORD[`EPC_CTRL_HIGH_EN] <= (POSITION > high_position_limit);
         end
      end
   end

   // velocity message scheduling: SYNC divider or cyclic timer
   always @(posedge CORE_CLK) begin
      VEL_SEND <= 1'b0;
      if (RESET || state != ST_IDLE) begin
         sync_count <= 8'h00;
         ms_count <= 16'h0000;
      end else if (!velocity_msg_identifier[`EPC_ID_DISABLE]) begin
         if (velocity_msg_transmit_type == `EPC_TX_ASYNC) begin
            if (cyclic_timer == 16'h0000) begin
               ms_count <= 16'h0000;
            end else if (tick) begin
               if (ms_count + 16'h0001 >= cyclic_timer) begin
                  ms_count <= 16'h0000;
                  VEL_SEND <= 1'b1;
               end else begin
                  ms_count <= ms_count + 16'h0001;
               end
            end
         end else if (velocity_msg_transmit_type != 8'h00 && SYNC_SEEN) begin
            if (sync_count + 8'h01 >= velocity_msg_transmit_type) begin
               sync_count <= 8'h00;
               VEL_SEND <= 1'b1;
            end else begin
               sync_count <= sync_count + 8'h01;
            end
         end
      end
   end

   // identifier format and per-message enables
   always @(posedge CORE_CLK) begin
      if (RESET) begin
         VEL_IDENT <= 29'h00000000;
         VEL_IDENT_EXT <= 1'b0;
         MSG_ENABLE <= 4'h0;
      end else begin
         VEL_IDENT_EXT <= velocity_msg_identifier[`EPC_ID_EXT];
         if (velocity_msg_identifier[`EPC_ID_EXT]) begin
            VEL_IDENT <= velocity_msg_identifier[28:0];
         end else begin
            VEL_IDENT <= {18'h00000, velocity_msg_identifier[10:0]};
         end
         MSG_ENABLE <= {~velocity_msg_identifier[31], ~other_ident[2][31],
                        ~other_ident[1][31], ~other_ident[0][31]};
      end
   end

endmodule // epc_config
`default_nettype wire

// File: hdl/epc_defines.vh
`ifndef EPC_DEFINES_VH
`define EPC_DEFINES_VH
// object selectors on the configuration write/read port
`define EPC_OBJ_IDENT     4'h0
`define EPC_OBJ_TXTYPE    4'h1
`define EPC_OBJ_MAP1      4'h2
`define EPC_OBJ_MAP2      4'h3
`define EPC_OBJ_MAP3      4'h4
`define EPC_OBJ_MAP4      4'h5
`define EPC_OBJ_LOWLIM    4'h6
`define EPC_OBJ_HIGHLIM   4'h7
`define EPC_OBJ_RATE      4'h8
`define EPC_OBJ_ADDR      4'h9
`define EPC_OBJ_CTRL      4'hA
`define EPC_OBJ_TIMER     4'hB
`define EPC_OBJ_STORE     4'hC
// field positions
`define EPC_ID_DISABLE    31
`define EPC_ID_NORTR      30
`define EPC_ID_EXT        29
`define EPC_CTRL_LOW_EN   12
`define EPC_CTRL_HIGH_EN  13
// reset values, limits and fixed codes
`define EPC_IDENT_BASE    32'hC0000480
`define EPC_TXTYPE_RST    8'hFE
`define EPC_TX_ASYNC      8'hFE
`define EPC_TX_SYNC_MAX   8'hF0
`define EPC_MAP_POS_RST   32'h60040020
`define EPC_MAP_VEL_RST   32'h30060020
`define EPC_LOWLIM_RST    32'h00000010
`define EPC_HIGHLIM_RST   32'h003FFFF0
`define EPC_RATE_RST      8'h05
`define EPC_ADDR_RST      8'h01
`define EPC_ADDR_MAX      8'h7F
`define EPC_ABORT_BADVAL  32'h06090030
`define EPC_BOOT_BASE     11'h700
// timer: one millisecond tick at 25 MHz
`define EPC_TICK_NS       1000000
`define EPC_CLK_NS        40
`define EPC_TICK_CYCLES   (`EPC_TICK_NS / `EPC_CLK_NS)
`define EPC_TICK_LAST     15'h61A7 // tick cycles less one, sized for the counter
`endif

// File: verification/epc_config_assertions.sv
`include "epc_defines.vh"
`default_nettype none
module epc_config_assertions (
   // clock and reset
   input wire logic        CORE_CLK,
   input wire logic        RESET,
   // configuration access
   input wire logic        CFG_WRITE,
   input wire logic        CFG_READ,
   input wire logic [3:0]  CFG_OBJECT,
   input wire logic [31:0] CFG_WDATA,
   input wire logic        CFG_DONE,
   input wire logic        CFG_ABORT,
   input wire logic [31:0] CFG_ABORT_CODE,
   // events and results
   input wire logic        NODE_RESET,
   input wire logic [6:0]  ACTIVE_ADDRESS,
   input wire logic        VEL_SEND,
   input wire logic [3:0]  MSG_ENABLE,
   input wire logic        BOOT_SEND,
   input wire logic [10:0] BOOT_IDENT
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (RESET);
   // write requests grouped by object
   wire wr_type = CFG_WRITE && (CFG_OBJECT == `EPC_OBJ_TXTYPE);
   wire wr_rate = CFG_WRITE && (CFG_OBJECT == `EPC_OBJ_RATE);
   wire wr_addr = CFG_WRITE && (CFG_OBJECT == `EPC_OBJ_ADDR);
   sequence s_abort;
      CFG_ABORT && !CFG_DONE && (CFG_ABORT_CODE == 32'h06090030);
   endsequence
   sequence s_boot;
      BOOT_SEND && (BOOT_IDENT == 11'h700 + {4'h0, ACTIVE_ADDRESS});
   endsequence
   property p_type_abort;
      wr_type && (CFG_WDATA > 32'hF0) && (CFG_WDATA != 32'hFE) |=> s_abort;
   endproperty
   a_type_abort: assert property (p_type_abort) else $error("type not refused");
   property p_type_zero;
      wr_type && (CFG_WDATA == 32'h0) |=> CFG_DONE && !CFG_ABORT;
   endproperty
   a_type_zero: assert property (p_type_zero) else $error("type zero refused");
   property p_rate_abort;
      wr_rate && (CFG_WDATA > 32'h07) |=> s_abort;
   endproperty
   a_rate_abort: assert property (p_rate_abort) else $error("rate not refused");
   property p_addr_abort;
      wr_addr && ((CFG_WDATA == 32'h0) || (CFG_WDATA > 32'h7F)) |=> s_abort;
   endproperty
   a_addr_abort: assert property (p_addr_abort) else $error("address not refused");
   // an answer only ever follows a request
   property p_no_answer;
      !CFG_WRITE && !CFG_READ |=> !CFG_DONE && !CFG_ABORT;
   endproperty
   a_no_answer: assert property (p_no_answer) else $error("answer without request");
   property p_boot_node;
      NODE_RESET |-> ##[1:4] s_boot;
   endproperty
   a_boot_node: assert property (p_boot_node) else $error("no boot after node reset");
   property p_boot_power;
      $fell(RESET) |-> ##[0:3] s_boot;
   endproperty
   a_boot_power: assert property (p_boot_power) else $error("no boot after reset");
   property p_addr_valid;
      ACTIVE_ADDRESS != 7'h00;
   endproperty
   a_addr_valid: assert property (p_addr_valid) else $error("address zero in use");
   // past value allowed: a disabling write may land with the send
   property p_vel_enabled;
      VEL_SEND |-> MSG_ENABLE[3] || $past(MSG_ENABLE[3]);
   endproperty
   a_vel_enabled: assert property (p_vel_enabled) else $error("disabled message sent");
endmodule // epc_config_assertions
`default_nettype wire

// File: verification/epc_master_model.sv
`include "epc_defines.vh"
`default_nettype none
module epc_master_model (
   // clock
   input  wire logic        clk,
   // configuration port
   output logic             cfg_write,
   output logic             cfg_read,
   output logic [3:0]       cfg_object,
   output logic [31:0]      cfg_wdata,
   input  wire logic        cfg_done,
   input  wire logic        cfg_abort,
   input  wire logic [31:0] cfg_rdata,
   // bus events
   output logic             sync_seen,
   output logic             node_reset
);
   timeunit 1ns;
   timeprecision 1ns;
   // idle bus at time zero
   initial begin
      {cfg_write, cfg_read, sync_seen, node_reset} = 4'h0;
      cfg_object = 4'h0;
      cfg_wdata  = 32'h0;
   end
   // one access; answer taken one edge after acceptance
   task automatic access(input logic wr, input logic [3:0] obj, input logic [31:0] data,
                         output logic done, output logic abrt, output logic [31:0] rd);
      @(posedge clk);
      cfg_write  <= wr;
      cfg_read   <= !wr;
      cfg_object <= obj;
      cfg_wdata  <= (wr && obj == `EPC_OBJ_IDENT) ? (data | 32'h40000000) : data;
      @(posedge clk);
      cfg_write <= 1'b0;
      cfg_read  <= 1'b0;
      cfg_wdata <= ~data; // released data never keeps its last value
      @(posedge clk);
      done = cfg_done;
      abrt = cfg_abort;
      rd   = cfg_rdata;
   endtask
   // one-cycle bus event: sync or node reset
   task automatic pulse(input logic sync);
      @(posedge clk);
      sync_seen  <= sync;
      node_reset <= !sync;
      @(posedge clk);
      sync_seen  <= 1'b0;
      node_reset <= 1'b0;
   endtask
   // rate change: write code, reset node, then save
   task automatic set_rate(input logic [7:0] code);
      logic d, a;
      logic [31:0] r;
      access(1'b1, `EPC_OBJ_RATE, {24'h0, code}, d, a, r);
      pulse(1'b0);
      access(1'b1, `EPC_OBJ_STORE, 32'h1, d, a, r);
   endtask
endmodule // epc_master_model
`default_nettype wire

// File: verification/tb.sv
`include "epc_defines.vh"
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        CORE_CLK, RESET, POWER_ON, FORCE_ADDR_SET, CFG_WRITE, CFG_READ, SYNC_SEEN;
   logic        NODE_RESET, CFG_DONE, CFG_ABORT, VEL_SEND, VEL_IDENT_EXT, BOOT_SEND, STORE_REQ;
   logic [3:0]  CFG_OBJECT, BIT_RATE_SWITCH_BANK, MSG_ENABLE;
   logic [31:0] CFG_WDATA, CFG_RDATA, CFG_ABORT_CODE, POSITION, rd, v;
   logic [6:0]  NODE_ADDRESS_SWITCH_BANK, ACTIVE_ADDRESS;
   logic [2:0]  ACTIVE_RATE;
   logic [15:0] STATUS_WORD;
   logic [28:0] VEL_IDENT;
   logic [10:0] BOOT_IDENT;
   logic        d, a;
   logic [3:0]  o;
   logic [31:0] shadow [0:15];
   logic [3:0]  co [0:7] = '{4'h1, 4'h1, 4'h1, 4'h1, 4'h8, 4'h9, 4'h9, 4'h9};
   logic [31:0] cv [0:7] = '{32'hF1, 32'hFF, 32'hFC, 32'h0, 32'h8, 32'h0, 32'h80, 32'h7F};
   logic [31:0] pc [0:3] = '{32'hF, 32'h11, 32'h3FFFF1, 32'h3FFFEF};
   int          error_cnt = 0;
   int          cmp_count = 0;
   int          vel_cnt, store_cnt, boot_cnt, n, t;
   epc_config i_epc_config (.CORE_CLK(CORE_CLK), .RESET(RESET), .POWER_ON(POWER_ON),
      .FORCE_ADDR_SET(FORCE_ADDR_SET), .CFG_WRITE(CFG_WRITE), .CFG_READ(CFG_READ),
      .CFG_OBJECT(CFG_OBJECT), .CFG_WDATA(CFG_WDATA), .CFG_RDATA(CFG_RDATA),
      .CFG_DONE(CFG_DONE), .CFG_ABORT(CFG_ABORT), .CFG_ABORT_CODE(CFG_ABORT_CODE),
      .SYNC_SEEN(SYNC_SEEN), .NODE_RESET(NODE_RESET), .POSITION(POSITION),
      .BIT_RATE_SWITCH_BANK(BIT_RATE_SWITCH_BANK),
      .NODE_ADDRESS_SWITCH_BANK(NODE_ADDRESS_SWITCH_BANK), .ACTIVE_RATE(ACTIVE_RATE),
      .ACTIVE_ADDRESS(ACTIVE_ADDRESS), .STATUS_WORD(STATUS_WORD), .VEL_SEND(VEL_SEND),
      .VEL_IDENT(VEL_IDENT), .VEL_IDENT_EXT(VEL_IDENT_EXT), .MSG_ENABLE(MSG_ENABLE),
      .BOOT_SEND(BOOT_SEND), .BOOT_IDENT(BOOT_IDENT), .STORE_REQ(STORE_REQ));
   epc_master_model i_epc_master_model (.clk(CORE_CLK), .cfg_write(CFG_WRITE),
      .cfg_read(CFG_READ), .cfg_object(CFG_OBJECT), .cfg_wdata(CFG_WDATA),
      .cfg_done(CFG_DONE), .cfg_abort(CFG_ABORT), .cfg_rdata(CFG_RDATA),
      .sync_seen(SYNC_SEEN), .node_reset(NODE_RESET));
   // reset value of each readable object 0h to 9h
   function automatic logic [31:0] exp_reset(input logic [3:0] obj);
      case (obj)
         4'h0: return 32'hC0000481;
         4'h1: return 32'hFE;
         4'h5: return 32'h30060020;
         4'h6: return 32'h10;
         4'h7: return 32'h003FFFF0;
         4'h8: return 32'h05;
         4'h9: return 32'h01;
         default: return 32'h60040020;
      endcase
   endfunction
   // whether a write value is accepted
   function automatic logic exp_ok(input logic [3:0] obj, input logic [31:0] val);
      case (obj)
         4'h1: return (val <= 32'hF0) || (val == 32'hFE);
         4'h8: return val <= 32'h07;
         4'h9: return (val != 32'h0) && (val <= 32'h7F);
         default: return 1'b1;
      endcase
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test;
      $display("mismatches %0d comparisons %0d", error_cnt, cmp_count);
      if (error_cnt == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic rw(input logic wr, input logic [3:0] obj, input logic [31:0] data);
      i_epc_master_model.access(wr, obj, data, d, a, rd);
   endtask
   // n syncs per send: any phase gives syncs/n sends
   task automatic sync_run(input logic [7:0] ty, input int syncs, input int sends);
      rw(1'b1, `EPC_OBJ_TXTYPE, {24'h0, ty});
      vel_cnt = 0;
      repeat (syncs) i_epc_master_model.pulse(1'b1);
      repeat (4) @(posedge CORE_CLK);
      check(vel_cnt, sends);
   endtask
   // bounded wait for the next send, counting cycles
   task automatic wait_vel(output int cyc);
      cyc = 0;
      do begin
         @(posedge CORE_CLK);
         cyc++;
      end while (VEL_SEND !== 1'b1 && cyc < 30000);
   endtask
   initial begin
      CORE_CLK = 1'b0;
      forever #20 CORE_CLK = ~CORE_CLK;
   end
   // event counters
   always @(posedge CORE_CLK) begin
      if (VEL_SEND === 1'b1) vel_cnt++;
      if (STORE_REQ === 1'b1) store_cnt++;
      if (BOOT_SEND === 1'b1) boot_cnt++;
   end
   // hang guard, well past the expected run
   initial begin
      #5000000;
      error_cnt++;
      stop_test();
   end
   initial begin
      void'($urandom(20283));
      {RESET, POWER_ON, FORCE_ADDR_SET} = 3'b110;
      POSITION = 32'h0;
      BIT_RATE_SWITCH_BANK = 4'h0;
      NODE_ADDRESS_SWITCH_BANK = 7'h00;
      repeat (4) @(posedge CORE_CLK);
      RESET <= 1'b0;
      POWER_ON <= 1'b0;
      repeat (4) @(posedge CORE_CLK);
      check(MSG_ENABLE, 4'h0);
      for (n = 0; n < 10; n++) begin
         shadow[n] = exp_reset(n[3:0]);
         rw(1'b0, n[3:0], 32'h0);
         check(rd, shadow[n]);
      end
      // corner values first, then random writes with read-back
      for (n = 0; n < 40; n++) begin
         o = (n < 8) ? co[n] : 4'(1 + $urandom % 9);
         v = (n < 8) ? cv[n] : (($urandom % 2) ? $urandom : $urandom % 300);
         if (o == 4'h1 || o == 4'h8 || o == 4'h9) v = v & 32'hFF;
         rw(1'b1, o, v);
         check({d, a}, exp_ok(o, v) ? 2'b10 : 2'b01);
         if (a === 1'b1) check(CFG_ABORT_CODE, 32'h06090030);
         if (exp_ok(o, v)) shadow[o] = v;
         rw(1'b0, o, 32'h0);
         check(rd, shadow[o]);
      end
      rw(1'b1, `EPC_OBJ_LOWLIM, 32'h10);
      rw(1'b1, `EPC_OBJ_HIGHLIM, 32'h003FFFF0);
      rw(1'b1, `EPC_OBJ_CTRL, 32'h3000);
      for (n = 0; n < 12; n++) begin
         POSITION <= (n < 4) ? pc[n] : $urandom % 32'h00500000;
         repeat (4) @(posedge CORE_CLK);
         check(STATUS_WORD[13:12], {POSITION > 32'h003FFFF0, POSITION < 32'h10});
      end
      POSITION <= 32'h5;
      rw(1'b1, `EPC_OBJ_CTRL, 32'h0);
      repeat (4) @(posedge CORE_CLK);
      check(STATUS_WORD[13:12], 2'b00);
      rw(1'b1, `EPC_OBJ_IDENT, 32'h2ABCDE12);
      @(posedge CORE_CLK);
      check({VEL_IDENT_EXT, VEL_IDENT, MSG_ENABLE[3]}, {1'b1, 29'h0ABCDE12, 1'b1});
      rw(1'b1, `EPC_OBJ_IDENT, 32'h80000485);
      sync_run(8'h01, 3, 0);
      rw(1'b1, `EPC_OBJ_IDENT, 32'h00000485);
      @(posedge CORE_CLK);
      check({VEL_IDENT_EXT, VEL_IDENT, MSG_ENABLE[3]}, {1'b0, 29'h485, 1'b1});
      sync_run(8'h01, 3, 3);
      sync_run(8'h02, 6, 3);
      t = 3 + $urandom % 18;
      sync_run(t[7:0], 3 * t, 3);
      sync_run(8'hF0, 240, 1);
      sync_run(8'h00, 5, 0);
      // timer-driven sends at one millisecond
      rw(1'b1, `EPC_OBJ_TXTYPE, 32'hFE);
      rw(1'b1, `EPC_OBJ_TIMER, 32'h1);
      wait_vel(t);
      wait_vel(t);
      check(t, `EPC_TICK_CYCLES);
      rw(1'b1, `EPC_OBJ_TIMER, 32'h0);
      vel_cnt = 0;
      repeat (26000) @(posedge CORE_CLK);
      check(vel_cnt, 0);
      BIT_RATE_SWITCH_BANK <= 4'hB;
      NODE_ADDRESS_SWITCH_BANK <= 7'h22;
      repeat (3) @(posedge CORE_CLK);
      boot_cnt = 0;
      i_epc_master_model.pulse(1'b0);
      repeat (6) @(posedge CORE_CLK);
      check({ACTIVE_RATE, ACTIVE_ADDRESS, BOOT_IDENT}, {3'h3, 7'h22, 11'h722});
      check(boot_cnt, 1);
      // warm reset: switch address must not force the identifier
      rw(1'b0, `EPC_OBJ_IDENT, 32'h0);
      check(rd, 32'h40000485);
      BIT_RATE_SWITCH_BANK <= 4'h3;
      NODE_ADDRESS_SWITCH_BANK <= 7'h00;
      rw(1'b1, `EPC_OBJ_ADDR, 32'h15);
      store_cnt = 0;
      i_epc_master_model.set_rate(8'h07);
      repeat (6) @(posedge CORE_CLK);
      check({ACTIVE_RATE, ACTIVE_ADDRESS, BOOT_IDENT}, {3'h7, 7'h15, 11'h715});
      check(store_cnt, 1);
      // cold restart in mid-run with the address on the switches
      NODE_ADDRESS_SWITCH_BANK <= 7'h2A;
      {RESET, POWER_ON} <= 2'b11;
      repeat (4) @(posedge CORE_CLK);
      {RESET, POWER_ON} <= 2'b00;
      repeat (4) @(posedge CORE_CLK);
      rw(1'b0, `EPC_OBJ_IDENT, 32'h0);
      check(rd, 32'hC00004AA);
      check({ACTIVE_ADDRESS, BOOT_IDENT}, {7'h2A, 11'h72A});
      stop_test();
   end
endmodule // tb
bind epc_config epc_config_assertions i_epc_config_assertions (.CORE_CLK(CORE_CLK),
   .RESET(RESET), .CFG_WRITE(CFG_WRITE), .CFG_READ(CFG_READ), .CFG_OBJECT(CFG_OBJECT),
   .CFG_WDATA(CFG_WDATA), .CFG_DONE(CFG_DONE), .CFG_ABORT(CFG_ABORT),
   .CFG_ABORT_CODE(CFG_ABORT_CODE), .NODE_RESET(NODE_RESET), .ACTIVE_ADDRESS(ACTIVE_ADDRESS),
   .VEL_SEND(VEL_SEND), .MSG_ENABLE(MSG_ENABLE), .BOOT_SEND(BOOT_SEND),
   .BOOT_IDENT(BOOT_IDENT));
`default_nettype wire
